// ### core/line_tx_path_config.sv
`timescale 1ns/100ps
module line_tx_path_config (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [tx_cfg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [tx_cfg_pkg::DATA_W-1:0] reg_wdata,
  output logic [tx_cfg_pkg::DATA_W-1:0] reg_rdata,
  input wire logic broadcast_en,
  input wire logic [tx_cfg_pkg::NUM_CH-1:0] tx_channel_clock,
  input wire logic [tx_cfg_pkg::NUM_CH-1:0] tx_single_rail_in,
  input wire tx_cfg_pkg::rail_s [tx_cfg_pkg::NUM_CH-1:0] tx_dual_rail_in,
  output tx_cfg_pkg::rail_s [tx_cfg_pkg::NUM_CH-1:0] line_rail_out,
  output logic [tx_cfg_pkg::NUM_CH-1:0] line_rail_valid,
  input wire logic [tx_cfg_pkg::NUM_CH-1:0] line_rail_ready,
  output logic [tx_cfg_pkg::NUM_CH-1:0] tx_powered,
  output logic [tx_cfg_pkg::NUM_CH-1:0] driver_oe,
  output logic [tx_cfg_pkg::NUM_CH-1:0] driver_failure_monitor,
  output logic [tx_cfg_pkg::NUM_CH-1:0] fifo_overflow,
  output logic [4*tx_cfg_pkg::NUM_CH-1:0] pulse_template_select
);
  import tx_cfg_pkg::*;
  logic [7:0] first_r [NUM_CH];
  logic [7:0] second_r [NUM_CH];
  logic [7:0] third_r [NUM_CH];
  logic [7:0] rdata_nxt;
  logic [1:0] ch_sel_w;
  logic [5:0] ofs_w;
  assign ch_sel_w = reg_addr[7:6];
  assign ofs_w = reg_addr[5:0];
  always_comb
  begin
    case (ofs_w)
      OFS_TX_CONFIG_FIRST: rdata_nxt = first_r[ch_sel_w] & MASK_FIRST;
      OFS_TX_CONFIG_SECOND: rdata_nxt = second_r[ch_sel_w] & MASK_SECOND;
      OFS_TX_CONFIG_THIRD: rdata_nxt = third_r[ch_sel_w];
      default: rdata_nxt = 8'h00;
    endcase
  end
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_nxt;
  end
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++)
    begin : g_ch
      ch_cfg_s cfg_w;
      logic hit_w, cfg_sy1_r, cfg_sy2_r;
      logic [2:0] lc_s1_r, lc_s2_r;
      logic rise_q_r, fall_q_r;
      logic d_rise_r, p_rise_r, n_rise_r, d_fall_r, p_fall_r, n_fall_r;
      logic d_w, p_w, n_w, inv_w;
      logic [1:0] lc_mode_w;
      logic last_one_r, enc_p_w, enc_n_w;
      logic [1:0] zero_cnt_r;
      logic pulse_cnt_odd_r;
      logic fifo_ready_w, tx_tick_r, tick_s1_r, tick_s2_r, tick_s3_r;
      logic [1:0] sc_dummy_w;
      assign hit_w = reg_wr && (broadcast_en || ch_sel_w == 2'(c));
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          first_r[c] <= RST_FIRST;
          second_r[c] <= RST_SECOND;
          third_r[c] <= RST_THIRD;
        end
        else if (hit_w)
        begin
          if (ofs_w == OFS_TX_CONFIG_FIRST)
            first_r[c] <= reg_wdata & MASK_FIRST;
          if (ofs_w == OFS_TX_CONFIG_SECOND)
            second_r[c] <= reg_wdata & MASK_SECOND;
          if (ofs_w == OFS_TX_CONFIG_THIRD)
            third_r[c] <= reg_wdata;
        end
      end
      assign cfg_w.pwr_down = first_r[c][BIT_PWR_DOWN];
      assign cfg_w.invert = first_r[c][BIT_INVERT];
      assign cfg_w.edge_rise = first_r[c][BIT_EDGE];
      assign cfg_w.mode = first_r[c][1:0];
      assign cfg_w.mon_dis = second_r[c][BIT_MON_DIS];
      assign cfg_w.high_z = second_r[c][BIT_HIGH_Z];
      assign cfg_w.template_sel = second_r[c][3:0];
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          tx_powered[c] <= 1'b0;
          driver_oe[c] <= 1'b0;
          driver_failure_monitor[c] <= 1'b0;
          pulse_template_select[4*c+:4] <= 4'h0;
        end
        else
        begin
          tx_powered[c] <= !cfg_w.pwr_down;
          driver_oe[c] <= !cfg_w.pwr_down && !cfg_w.high_z;
          driver_failure_monitor[c] <= !cfg_w.mon_dis && !cfg_w.pwr_down;
          pulse_template_select[4*c+:4] <= cfg_w.template_sel;
        end
      end
      // Link side: config levels cross with two flops
      always_ff @(posedge tx_channel_clock[c] or negedge rst_n)
      begin
        if (!rst_n)
        begin
          lc_s1_r <= 3'h0;
          lc_s2_r <= 3'h0;
        end
        else
        begin
          lc_s1_r <= {cfg_w.invert, cfg_w.mode};
          lc_s2_r <= lc_s1_r;
        end
      end
      assign inv_w = lc_s2_r[2];
      assign lc_mode_w = lc_s2_r[1:0];
      // Pins captured on both edges; edge select chooses
      always_ff @(posedge tx_channel_clock[c] or negedge rst_n)
      begin
        if (!rst_n)
        begin
          d_rise_r <= 1'b0;
          p_rise_r <= 1'b0;
          n_rise_r <= 1'b0;
        end
        else
        begin
          d_rise_r <= tx_single_rail_in[c];
          p_rise_r <= tx_dual_rail_in[c].pos;
          n_rise_r <= tx_dual_rail_in[c].neg;
        end
      end
      always_ff @(negedge tx_channel_clock[c] or negedge rst_n)
      begin
        if (!rst_n)
        begin
          d_fall_r <= 1'b0;
          p_fall_r <= 1'b0;
          n_fall_r <= 1'b0;
        end
        else
        begin
          d_fall_r <= tx_single_rail_in[c];
          p_fall_r <= tx_dual_rail_in[c].pos;
          n_fall_r <= tx_dual_rail_in[c].neg;
        end
      end
      always_ff @(posedge tx_channel_clock[c] or negedge rst_n)
      begin
        if (!rst_n)
        begin
          rise_q_r <= 1'b0;
          fall_q_r <= 1'b0;
        end
        else
        begin
          rise_q_r <= cfg_w.edge_rise;
          fall_q_r <= rise_q_r;
        end
      end
      assign d_w = (fall_q_r ? d_rise_r : d_fall_r) ^ inv_w;
      assign p_w = (fall_q_r ? p_rise_r : p_fall_r) ^ inv_w;
      assign n_w = (fall_q_r ? n_rise_r : n_fall_r) ^ inv_w;
      // Substitution simplified: fourth zero forced as an alternating mark, not a violation
      always_ff @(posedge tx_channel_clock[c] or negedge rst_n)
      begin
        if (!rst_n)
        begin
          last_one_r <= 1'b0;
          zero_cnt_r <= 2'h0;
          pulse_cnt_odd_r <= 1'b0;
        end
        else if (!lc_mode_w[1] && fifo_ready_w)
        begin
          if (d_w || (lc_mode_w == MODE_HDB3 && zero_cnt_r == 2'h3))
          begin
            last_one_r <= !last_one_r;
            zero_cnt_r <= 2'h0;
            pulse_cnt_odd_r <= !pulse_cnt_odd_r;
          end
          else
            zero_cnt_r <= zero_cnt_r + 2'h1;
        end
      end
      assign enc_p_w = (d_w || (lc_mode_w == MODE_HDB3 && zero_cnt_r == 2'h3)) && !last_one_r;
      assign enc_n_w = (d_w || (lc_mode_w == MODE_HDB3 && zero_cnt_r == 2'h3)) && last_one_r;
      assign sc_dummy_w = lc_mode_w[1] ? {p_w, n_w} : {enc_p_w, enc_n_w};
      tx_sync_fifo #(.WIDTH(2), .DEPTH(FIFO_DEPTH)) u_fifo (
        .wr_clk(tx_channel_clock[c]),
        .rd_clk(sys_clk),
        .rst_n(rst_n),
        .in_data(sc_dummy_w),
        .in_valid(1'b1),
        .in_ready(fifo_ready_w),
        .out_data(line_rail_out[c]),
        .out_valid(line_rail_valid[c]),
        .out_ready(line_rail_ready[c])
      );
      // Overflow flag crosses as toggle-free level
      always_ff @(posedge tx_channel_clock[c] or negedge rst_n)
      begin
        if (!rst_n)
          tx_tick_r <= 1'b0;
        else if (!fifo_ready_w)
          tx_tick_r <= 1'b1;
      end
      always_ff @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          tick_s1_r <= 1'b0;
          tick_s2_r <= 1'b0;
          tick_s3_r <= 1'b0;
          fifo_overflow[c] <= 1'b0;
        end
        else
        begin
          tick_s1_r <= tx_tick_r;
          tick_s2_r <= tick_s1_r;
          tick_s3_r <= tick_s2_r;
          fifo_overflow[c] <= tick_s3_r;
        end
      end
    end
  endgenerate
endmodule : line_tx_path_config

// ### core/tx_cfg_pkg.sv
// Operation
// - Four channels each hold own transmit registers
// - Power-down bit disables transmitter, driver high-Z
// - Invert clear: transmit data active high
// - Invert set: transmit data inverted, active low
// - Edge select clear: sample on falling edge
// - Edge select set: sample on rising edge
// - Mode 00: single rail, HDB3/B8ZS encoding
// - Mode 01: single rail, AMI encoding
// - Mode 1x: encoder bypassed, dual rail input
// - Bit 5 disables driver failure monitor
// - Bit 4 puts only driver high-Z
// - Four-bit field selects pulse template/build out
// - Broadcast writes copy to all channels
package tx_cfg_pkg;
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [5:0] OFS_TX_CONFIG_FIRST = 6'h02;
  localparam logic [5:0] OFS_TX_CONFIG_SECOND = 6'h03;
  localparam logic [5:0] OFS_TX_CONFIG_THIRD = 6'h04;
  localparam logic [7:0] MASK_FIRST = 8'h1F;
  localparam logic [7:0] MASK_SECOND = 8'h3F;
  localparam logic [7:0] RST_FIRST = 8'h00;
  localparam logic [7:0] RST_SECOND = 8'h10;
  localparam logic [7:0] RST_THIRD = 8'h00;
  localparam int BIT_PWR_DOWN = 4;
  localparam int BIT_INVERT = 3;
  localparam int BIT_EDGE = 2;
  localparam int BIT_MON_DIS = 5;
  localparam int BIT_HIGH_Z = 4;
  localparam int FIFO_DEPTH = 8;
  localparam logic [1:0] MODE_HDB3 = 2'h0;
  localparam logic [1:0] MODE_AMI = 2'h1;
  typedef struct packed {
    logic pwr_down;
    logic invert;
    logic edge_rise;
    logic [1:0] mode;
    logic mon_dis;
    logic high_z;
    logic [3:0] template_sel;
  } ch_cfg_s;
  typedef struct packed {
    logic pos;
    logic neg;
  } rail_s;
endpackage : tx_cfg_pkg

// ### core/tx_sync_fifo.sv
`timescale 1ns/100ps
module tx_sync_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 8
) (
  input wire logic wr_clk,
  input wire logic rd_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wp_r, rp_r, wg_r, rg_r, wg_s1_r, wg_s2_r, rg_s1_r, rg_s2_r;
  logic [AW:0] wp_nxt, rp_nxt, wg_nxt, rg_nxt;
  logic full_w, empty_w, do_wr, do_rd;
  // Gray pointers cross domains; binary stays local
  assign wp_nxt = wp_r + (AW+1)'(do_wr);
  assign rp_nxt = rp_r + (AW+1)'(do_rd);
  assign wg_nxt = wp_nxt ^ (wp_nxt >> 1);
  assign rg_nxt = rp_nxt ^ (rp_nxt >> 1);
  assign full_w = (wg_r == {~rg_s2_r[AW:AW-1], rg_s2_r[AW-2:0]});
  assign empty_w = (rg_r == wg_s2_r);
  assign do_wr = in_valid && !full_w;
  assign do_rd = out_ready && !empty_w;
  assign in_ready = !full_w;
  assign out_valid = !empty_w;
  assign out_data = mem_r[rp_r[AW-1:0]];
  always_ff @(posedge wr_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_r <= '0;
      wg_r <= '0;
      rg_s1_r <= '0;
      rg_s2_r <= '0;
    end
    else
    begin
      wp_r <= wp_nxt;
      wg_r <= wg_nxt;
      rg_s1_r <= rg_r;
      rg_s2_r <= rg_s1_r;
    end
  end
  always_ff @(posedge wr_clk)
  begin
    if (do_wr)
      mem_r[wp_r[AW-1:0]] <= in_data;
  end
  always_ff @(posedge rd_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rp_r <= '0;
      rg_r <= '0;
      wg_s1_r <= '0;
      wg_s2_r <= '0;
    end
    else
    begin
      rp_r <= rp_nxt;
      rg_r <= rg_nxt;
      wg_s1_r <= wg_r;
      wg_s2_r <= wg_s1_r;
    end
  end
endmodule : tx_sync_fifo

// ### tb/line_tx_properties.sv
`timescale 1ns/100ps
module line_tx_properties (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic broadcast_en,
  input wire logic [3:0] tx_powered,
  input wire logic [3:0] driver_oe,
  input wire logic [3:0] driver_failure_monitor,
  input wire logic [15:0] pulse_template_select
);
  import tx_cfg_pkg::*;
  wire [1:0] ch = reg_addr[7:6];
  wire [5:0] ofs = reg_addr[5:0];
  wire wr_one = reg_wr && !broadcast_en;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // Write checks take two edges: register, then output flop; read checks take one
  oe_needs_power_a:
    assert property (|(driver_oe & ~tx_powered) == 1'b0) else $error("driver on while powered down");
  pwr_write_a:
    assert property (wr_one && ofs == 6'h02 |=> ##1 tx_powered[$past(ch, 2)] == !$past(reg_wdata[4], 2))
      else $error("power bit not applied");
  bcast_write_a:
    assert property (reg_wr && broadcast_en && ofs == 6'h02 |=> ##1 tx_powered == {4{!$past(reg_wdata[4], 2)}})
      else $error("broadcast not copied");
  high_z_a:
    assert property (wr_one && ofs == 6'h03 |=> ##1
      driver_oe[$past(ch, 2)] == (!$past(reg_wdata[4], 2) && tx_powered[$past(ch, 2)]))
      else $error("driver enable wrong");
  mon_dis_a:
    assert property (wr_one && ofs == 6'h03 |=> ##1
      driver_failure_monitor[$past(ch, 2)] == (!$past(reg_wdata[5], 2) && tx_powered[$past(ch, 2)]))
      else $error("monitor enable wrong");
  template_a:
    assert property (wr_one && ofs == 6'h03 |=> ##1
      pulse_template_select[$past(ch, 2) * 4 +: 4] == $past(reg_wdata[3:0], 2))
      else $error("template not applied");
  rsv_read_a:
    assert property (reg_rd && ofs == 6'h02 |=> reg_rdata[7:5] == 3'h0) else $error("reserved bits set");
  unmapped_read_a:
    assert property (reg_rd && (ofs < 6'h02 || ofs > 6'h04) |=> reg_rdata == 8'h00) else $error("unmapped read");
endmodule : line_tx_properties

bind line_tx_path_config line_tx_properties props (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .broadcast_en(broadcast_en), .tx_powered(tx_powered),
  .driver_oe(driver_oe), .driver_failure_monitor(driver_failure_monitor),
  .pulse_template_select(pulse_template_select)
);

// ### tb/tx_framer_model.sv
`timescale 1ns/100ps
module tx_framer_model (
  input wire logic sd,
  input wire tx_cfg_pkg::rail_s dd,
  output logic [3:0] clk,
  output logic [3:0] sdo,
  output tx_cfg_pkg::rail_s [3:0] ddo
);
  import tx_cfg_pkg::*;
  // Line clock runs free, as a framer's would
  initial
  begin
    clk = 4'h0;
    sdo = 4'h0;
    ddo = '0;
    #3;
    forever
    begin
      #12;
      // Moves midway; inverse level before rising edges exposes a wrong edge
      sdo = clk[0] ? {4{sd}} : {4{~sd}};
      ddo = clk[0] ? {4{dd}} : {4{rail_s'(~dd)}};
      #12;
      clk = ~clk;
    end
  end
endmodule : tx_framer_model

// ### tb/tb_line_tx_path_config.sv
`timescale 1ns/100ps
module tb_line_tx_path_config;
  import tx_cfg_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, broadcast_en = 1'b0, sd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [3:0] tck, sdi, valid, pwr, oe, mon, ovf;
  logic [3:0] ready = 4'hF;
  logic [15:0] tmpl;
  rail_s dd = 2'h0;
  rail_s w, p;
  rail_s [3:0] ddi, lout;
  int fails = 0, total_checks = 0;
  int k;
  line_tx_path_config dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .broadcast_en(broadcast_en), .tx_channel_clock(tck),
    .tx_single_rail_in(sdi), .tx_dual_rail_in(ddi), .line_rail_out(lout), .line_rail_valid(valid),
    .line_rail_ready(ready), .tx_powered(pwr), .driver_oe(oe), .driver_failure_monitor(mon),
    .fifo_overflow(ovf), .pulse_template_select(tmpl)
  );
  tx_framer_model far (.sd(sd), .dd(dd), .clk(tck), .sdo(sdi), .ddo(ddi));
  initial
  begin
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    #1 chk(reg_rdata, e);
  endtask : rd
  // Skip lets stale words of the old mode drain
  task automatic get(input int skip, output rail_s q);
    int n;
    repeat (skip) @(posedge sys_clk);
    for (n = 0; n < 40; n++)
    begin
      @(posedge sys_clk);
      #1;
      if (valid[0] === 1'b1)
        break;
    end
    if (n == 40)
    begin
      fails++;
      final_report();
    end
    q = lout[0];
  endtask : get
  task automatic count4(output int cnt);
    rail_s q;
    cnt = 0;
    repeat (4)
    begin
      get(0, q);
      if (q != 2'h0)
        cnt++;
    end
  endtask : count4
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1 chk({pwr, oe}, 8'hF0);
    for (int c = 0; c < 4; c++)
    begin
      rd({c[1:0], 6'h02}, 8'h00);
      rd({c[1:0], 6'h03}, 8'h10);
      rd({c[1:0], 6'h04}, 8'h00);
    end
    $display("reset values done");
    wr(8'h42, 8'h1F);
    #1 chk(pwr, 4'hD);
    rd(8'h42, 8'h1F);
    rd(8'h02, 8'h00);
    wr(8'h82, 8'hFF);
    rd(8'h82, 8'h1F);
    wr(8'hC3, 8'hFF);
    rd(8'hC3, 8'h3F);
    wr(8'h44, 8'hA5);
    rd(8'h44, 8'hA5);
    wr(8'h05, 8'h77);
    rd(8'h05, 8'h00);
    $display("access done");
    wr(8'h03, 8'h00);
    #1 chk({oe[0], mon[0]}, 2'h3);
    wr(8'h03, 8'h20);
    #1 chk({oe[0], mon[0]}, 2'h2);
    for (int t = 0; t < 16; t++)
    begin
      wr(8'h03, {4'h2, t[3:0]});
      #1 chk(tmpl[3:0], t[3:0]);
    end
    @(posedge sys_clk);
    broadcast_en <= 1'b1;
    wr(8'h02, 8'h10);
    #1 chk(pwr, 4'h0);
    wr(8'h02, 8'h00);
    #1 chk(pwr, 4'hF);
    @(posedge sys_clk);
    broadcast_en <= 1'b0;
    $display("driver and broadcast done");
    dd <= 2'h2;
    sd <= 1'b1;
    wr(8'h02, 8'h02);
    get(100, w);
    chk(w, 2'h2);
    wr(8'h02, 8'h0E);
    get(100, w);
    chk(w, 2'h2);
    wr(8'h02, 8'h01);
    get(100, w);
    get(0, p);
    chk(w ^ p, 2'h3);
    wr(8'h02, 8'h00);
    get(100, w);
    get(0, p);
    chk(w ^ p, 2'h3);
    // Zero runs: fourth zero forced in HDB3, AMI stays idle
    sd <= 1'b0;
    get(100, w);
    count4(k);
    chk(16'(k), 16'h0001);
    wr(8'h02, 8'h01);
    get(100, w);
    count4(k);
    chk(16'(k), 16'h0000);
    chk(ovf, 4'h0);
    // Stall the drain well past eight link bits
    ready <= 4'h0;
    repeat (200) @(posedge sys_clk);
    #1 chk(ovf, 4'hF);
    // Overflow is sticky; only reset clears it
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1 chk({ovf, pwr, oe}, 12'h0F0);
    rd(8'h42, 8'h00);
    $display("data path done");
    final_report();
  end
endmodule : tb_line_tx_path_config
